// file: src/rtchp_pkg.sv
// Constants for the clock chip host port, address map and rate logic
package rtchp_pkg;

  // Clock and timebase
  localparam int CLK_HZ       = 32'h0262_5a00;  // 40 MHz
  localparam int TB_HZ        = 32'h0000_8000;  // 32.768 kHz divider input
  localparam int MS_PER_S     = 32'h0000_03e8;
  localparam int PWRUP_MS     = 32'h0000_00c8;  // 200 ms access guard
  localparam int PWRUP_CYCLES = CLK_HZ / MS_PER_S * PWRUP_MS;

  // Divider chain
  localparam int CHAIN_W      = 32'h0000_000f;

  // Address map
  localparam int ADDR_W       = 32'h0000_0007;
  localparam int DATA_W       = 32'h0000_0008;
  localparam int MAP_BYTES    = 32'h0000_0080;  // 128 locations
  localparam int EXT_BYTES    = 32'h0000_0040;  // extra 64-byte area
  localparam int EXT_SEL_BIT  = 32'h0000_0006;  // bus line 6 picks extra area
  localparam logic [6:0] ADDR_SECONDS   = 7'h00;
  localparam logic [6:0] ADDR_RATE_OSC  = 7'h0a;
  localparam logic [6:0] ADDR_MODE      = 7'h0b;
  localparam logic [6:0] ADDR_FLAGS     = 7'h0c;
  localparam logic [6:0] ADDR_VALID     = 7'h0d;
  localparam int USER_FIRST   = 32'h0000_000e;  // 114 bytes, 14 to 127
  localparam int USER_LAST    = 32'h0000_007f;

  // Field positions
  localparam int SEC_RO_BIT   = 32'h0000_0007;
  localparam int RATE_RO_BIT  = 32'h0000_0007;
  localparam int OSC_LSB      = 32'h0000_0004;
  localparam int MODE_PIE     = 32'h0000_0006;
  localparam int MODE_AIE     = 32'h0000_0005;
  localparam int MODE_UIE     = 32'h0000_0004;
  localparam int MODE_SQUARE_WAVE_ENABLE    = 32'h0000_0003;
  localparam int FLAG_SUMMARY = 32'h0000_0007;
  localparam int FLAG_PERIOD  = 32'h0000_0006;
  localparam int FLAG_ALARM   = 32'h0000_0005;
  localparam int FLAG_UPDATE  = 32'h0000_0004;

  // Oscillator control patterns in bits 6:4
  localparam logic [2:0] OSC_RUN        = 3'h2;
  localparam logic [1:0] OSC_CHAIN_RST  = 2'h3;  // 11X, top two bits

  // Reset and fixed values
  localparam logic [7:0] RATE_RESET     = 8'h26;
  localparam logic [7:0] MODE_RESET     = 8'h00;
  localparam logic [7:0] VALID_VALUE    = 8'h80;  // storage and time valid
  localparam logic [7:0] FILL_VALUE     = 8'hff;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;

  // Rate codes and taps
  localparam logic [3:0] RATE_NONE      = 4'h0;
  localparam logic [3:0] RATE_256HZ     = 4'h1;
  localparam logic [3:0] RATE_128HZ     = 4'h2;
  localparam logic [3:0] TAP_256HZ      = 4'h6;
  localparam logic [3:0] TAP_128HZ      = 4'h7;
  localparam logic [3:0] TAP_OFFSET     = 4'h2;  // codes 3..15 map to taps 1..13

  // Synchroniser slots
  localparam int SYNC_W       = 32'h0000_000e;
  localparam int SI_BUS       = 32'h0000_0000;
  localparam int SI_ALS       = 32'h0000_0008;
  localparam int SI_RD        = 32'h0000_0009;
  localparam int SI_WR        = 32'h0000_000a;
  localparam int SI_CS        = 32'h0000_000b;
  localparam int SI_LOW       = 32'h0000_000c;
  localparam int SI_CLR       = 32'h0000_000d;
  localparam logic [13:0] SYNC_RESET    = 14'h3e00;

endpackage : rtchp_pkg

// file: src/rtchp_host_port.sv
// Host port, storage map, interrupt and square-wave logic of the clock chip
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Address from bus bits 6:0 latched at falling address strobe, used next phase.
// - On reads the device drives eight data bits soon after the read strobe falls.
// - Read ends and bus floats when read strobe goes high.
// - Access only while select is low; unselected cycles still latch addresses.
// - Supply low forces select inactive, inputs ignored, outputs floated.
// - Accesses refused for 200 ms after supply valid, and unless divider runs.
// - Rate field picks periodic interrupt period; zero means none.
// - Square wave taken from one of thirteen divider taps chosen by rate.
// - Square wave toggles only while its enable bit is set, else held low.
// - No square wave while supply is low.
// - Interrupt line low while any flag and its enable are both set.
// - Interrupt pin only pulls low, floats otherwise; external pull-up.
// - Clear pin low at supply-up fills all 114 user bytes with ones.
// - 128 locations: ten time bytes, four control registers, 114 user bytes.
// - Writes to flag and valid registers ignored; reads give contents.
// - Bit 7 of rate register is read-only; other bits writable.
// - Top bit of the seconds byte is read-only.
// - Bus line six from address phase selects the extra 64-byte area.
// - Flag read clears flags and summary; events during read land afterwards, except one in the read's first cycle, which is dropped unread.
// - Flags set regardless of enable; late enable asserts interrupt at once.
// - Rate bits 6:4: 010 runs, 11X holds chain reset, others stop.
// - Three mode bits enable alarm, periodic and update-ended interrupts.
module rtchp_host_port #(
  parameter int POWER_UP_CYCLES = rtchp_pkg::PWRUP_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] sharedAddrDataBusIn,
  output logic      [7:0] sharedAddrDataBusOut,
  output logic            sharedAddrDataBusOe,
  input  wire logic       addressLatchStrobe,
  input  wire logic       readStrobeN,
  input  wire logic       writeStrobeN,
  input  wire logic       chipSelectN,
  input  wire logic       supplyLow,
  input  wire logic       userStorageClearN,
  input  wire logic       extAreaEnable,
  input  wire logic       alarmEvent,
  input  wire logic       updateEndedEvent,
  output logic            irqOut,
  output logic            irqOe,
  output logic            squareWaveOut,
  output logic            squareWaveOe
);

  localparam int TOTAL_BYTES = rtchp_pkg::MAP_BYTES + rtchp_pkg::EXT_BYTES;

  // Input synchronisers
  logic [rtchp_pkg::SYNC_W-1:0] rawIn;
  logic [rtchp_pkg::SYNC_W-1:0] syncA;
  logic [rtchp_pkg::SYNC_W-1:0] syncB;
  logic [rtchp_pkg::SYNC_W-1:0] syncC;
  logic [rtchp_pkg::SYNC_W-1:0] filt;
  logic [rtchp_pkg::SYNC_W-1:0] filtPrev;

  assign rawIn = {userStorageClearN, supplyLow, chipSelectN, writeStrobeN,
                  readStrobeN, addressLatchStrobe, sharedAddrDataBusIn};

  genvar gi;
  generate
    for (gi = 0; gi < rtchp_pkg::SYNC_W; gi++)
    begin : g_sync
      // Filter only looks at the second and third stages
      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          syncA[gi]    <= rtchp_pkg::SYNC_RESET[gi];
          syncB[gi]    <= rtchp_pkg::SYNC_RESET[gi];
          syncC[gi]    <= rtchp_pkg::SYNC_RESET[gi];
          filt[gi]     <= rtchp_pkg::SYNC_RESET[gi];
          filtPrev[gi] <= rtchp_pkg::SYNC_RESET[gi];
        end
        else
        begin
          syncA[gi]    <= rawIn[gi];
          syncB[gi]    <= syncA[gi];
          syncC[gi]    <= syncB[gi];
          if (syncB[gi] == syncC[gi])
            filt[gi] <= syncC[gi];
          filtPrev[gi] <= filt[gi];
        end
      end
    end
  endgenerate

  logic [7:0] busF;
  logic       lowF;
  logic       csActiveF;
  logic       alsFall;
  logic       rdFall;
  logic       rdRise;
  logic       wrRise;
  logic       supplyUp;

  assign busF      = filt[rtchp_pkg::SI_BUS +: rtchp_pkg::DATA_W];
  assign lowF      = filt[rtchp_pkg::SI_LOW];
  assign csActiveF = !filt[rtchp_pkg::SI_CS] && !lowF;
  assign alsFall   = filtPrev[rtchp_pkg::SI_ALS] && !filt[rtchp_pkg::SI_ALS];
  assign rdFall    = filtPrev[rtchp_pkg::SI_RD] && !filt[rtchp_pkg::SI_RD];
  assign rdRise    = !filtPrev[rtchp_pkg::SI_RD] && filt[rtchp_pkg::SI_RD];
  assign wrRise    = !filtPrev[rtchp_pkg::SI_WR] && filt[rtchp_pkg::SI_WR];
  assign supplyUp  = filtPrev[rtchp_pkg::SI_LOW] && !lowF;

  // Control registers
  logic [7:0] rateOsc;
  logic [7:0] modeCtl;
  logic [3:0] rateSel;
  logic       oscRun;
  logic       chainHold;

  assign rateSel   = rateOsc[3:0];
  assign oscRun    = rateOsc[rtchp_pkg::OSC_LSB +: 3] == rtchp_pkg::OSC_RUN;
  assign chainHold = rateOsc[rtchp_pkg::OSC_LSB + 1 +: 2] == rtchp_pkg::OSC_CHAIN_RST;

  // Power-up guard
  logic [31:0] guardCount;
  logic        guardDone;
  logic        accessOk;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      guardCount <= '0;
    else if (lowF)
      guardCount <= '0;
    else if (!guardDone)
      guardCount <= guardCount + 32'h0000_0001;
  end

  assign guardDone = guardCount >= POWER_UP_CYCLES;
  // Oscillator gating follows the register; the reset value runs the chain so
  // software is not locked out forever
  assign accessOk  = guardDone && oscRun && csActiveF;

  // Address phase
  logic [6:0] capAddr;
  logic       capExt;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      capAddr <= '0;
      capExt  <= 1'b0;
    end
    else if (alsFall && !lowF)
    begin
      // Latched even when the chip is not selected
      capAddr <= busF[rtchp_pkg::ADDR_W-1:0];
      capExt  <= extAreaEnable && busF[rtchp_pkg::EXT_SEL_BIT];
    end
  end

  logic [7:0] memIndex;
  logic       isCtrl;

  always_comb
  begin
    if (capExt)
      memIndex = {2'b10, capAddr[5:0]};
    else
      memIndex = {1'b0, capAddr};
    isCtrl = !capExt && capAddr >= rtchp_pkg::ADDR_RATE_OSC
             && capAddr <= rtchp_pkg::ADDR_VALID;
  end

  logic doWrite;
  logic doRead;
  assign doWrite = wrRise && accessOk;
  assign doRead  = rdFall && accessOk;

  // Storage, no reset: contents are battery backed
  logic [7:0] mem [0:TOTAL_BYTES-1];

  always_ff @(posedge ref_clk)
  begin
    if (supplyUp && !filt[rtchp_pkg::SI_CLR])
    begin
      for (int i = rtchp_pkg::USER_FIRST; i <= rtchp_pkg::USER_LAST; i++)
        mem[i] <= rtchp_pkg::FILL_VALUE;
    end
    else if (doWrite && !isCtrl)
    begin
      if (!capExt && capAddr == rtchp_pkg::ADDR_SECONDS)
        mem[memIndex] <= {mem[memIndex][rtchp_pkg::SEC_RO_BIT],
                          busF[rtchp_pkg::SEC_RO_BIT-1:0]};
      else
        mem[memIndex] <= busF;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rateOsc <= rtchp_pkg::RATE_RESET;
      modeCtl <= rtchp_pkg::MODE_RESET;
    end
    else if (doWrite && !capExt)
    begin
      if (capAddr == rtchp_pkg::ADDR_RATE_OSC)
        rateOsc <= {rateOsc[rtchp_pkg::RATE_RO_BIT],
                    busF[rtchp_pkg::RATE_RO_BIT-1:0]};
      else if (capAddr == rtchp_pkg::ADDR_MODE)
        modeCtl <= busF;
      // Flag and valid registers drop writes
    end
  end

  // Timebase and divider chain
  logic [31:0]                   tbAcc;
  logic [31:0]                   tbNext;
  logic                          tbTick;
  logic [rtchp_pkg::CHAIN_W-1:0] chain;

  assign tbNext = tbAcc + rtchp_pkg::TB_HZ;
  assign tbTick = tbNext >= rtchp_pkg::CLK_HZ;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      tbAcc <= '0;
    else if (tbTick)
      tbAcc <= tbNext - rtchp_pkg::CLK_HZ;
    else
      tbAcc <= tbNext;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      chain <= '0;
    else if (chainHold)
      chain <= '0;
    else if (oscRun && tbTick)
      chain <= chain + 15'h0001;
  end

  // Tap selection
  logic [3:0] tapIndex;
  logic       tapValue;
  logic       tapPrev;
  logic       rateOn;

  always_comb
  begin
    case (rateSel)
      rtchp_pkg::RATE_256HZ: tapIndex = rtchp_pkg::TAP_256HZ;
      rtchp_pkg::RATE_128HZ: tapIndex = rtchp_pkg::TAP_128HZ;
      rtchp_pkg::RATE_NONE:  tapIndex = '0;
      default:               tapIndex = rateSel - rtchp_pkg::TAP_OFFSET;
    endcase
  end

  assign tapValue = chain[tapIndex];
  assign rateOn   = rateSel != rtchp_pkg::RATE_NONE && oscRun;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      tapPrev <= 1'b0;
    else
      tapPrev <= tapValue;
  end

  // One full tap period elapses between falling edges
  logic periodicEvent;
  assign periodicEvent = rateOn && tapPrev && !tapValue;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      squareWaveOut <= 1'b0;
    else
      squareWaveOut <= modeCtl[rtchp_pkg::MODE_SQUARE_WAVE_ENABLE] && rateOn && !lowF
                       && tapValue;
  end

  assign squareWaveOe = !lowF;

  // Interrupt flags with double latching around a flag read
  logic [2:0] flags;
  logic [2:0] pending;
  logic [2:0] events;
  logic [2:0] enables;
  logic       flagReadBusy;
  logic       irqSummary;

  assign events  = {periodicEvent, alarmEvent, updateEndedEvent};
  assign enables = {modeCtl[rtchp_pkg::MODE_PIE], modeCtl[rtchp_pkg::MODE_AIE],
                    modeCtl[rtchp_pkg::MODE_UIE]};

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flags        <= '0;
      pending      <= '0;
      flagReadBusy <= 1'b0;
    end
    else if (flagReadBusy)
    begin
      if (rdRise || lowF)
      begin
        // Held events, and one arriving now, survive the clear
        flags        <= pending | events;
        pending      <= '0;
        flagReadBusy <= 1'b0;
      end
      else
        pending <= pending | events;
    end
    else
    begin
      flags <= flags | events;
      if (doRead && !capExt && capAddr == rtchp_pkg::ADDR_FLAGS)
        flagReadBusy <= 1'b1;
    end
  end

  assign irqSummary = |(flags & enables);
  assign irqOut     = 1'b0;
  assign irqOe      = irqSummary && !lowF;

  // Read data path
  logic [7:0] readValue;
  logic       readActive;

  always_comb
  begin
    if (capExt || !isCtrl)
      readValue = mem[memIndex];
    else
    begin
      case (capAddr)
        rtchp_pkg::ADDR_RATE_OSC: readValue = rateOsc;
        rtchp_pkg::ADDR_MODE:     readValue = modeCtl;
        rtchp_pkg::ADDR_FLAGS:    readValue = {irqSummary, flags,
                                               4'h0};
        rtchp_pkg::ADDR_VALID:    readValue = rtchp_pkg::VALID_VALUE;
        default:                  readValue = rtchp_pkg::ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      sharedAddrDataBusOut <= rtchp_pkg::ZERO_BYTE;
    else if (doRead)
      sharedAddrDataBusOut <= readValue;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      readActive <= 1'b0;
    else if (rdRise || lowF || !csActiveF)
      readActive <= 1'b0;
    else if (doRead)
      readActive <= 1'b1;
  end

  assign sharedAddrDataBusOe = readActive && !lowF;

endmodule : rtchp_host_port

`default_nettype wire

// file: dv/rtchp_host_bfm.sv
// Host bus model driving the multiplexed bus and its strobes
`timescale 1ns/10ps
`default_nettype none
module rtchp_host_bfm (
  input  wire logic       ref_clk,
  output logic      [7:0] busToDev,
  input  wire logic [7:0] busFromDev,
  input  wire logic       busOe,
  output logic            als,
  output logic            rdN,
  output logic            wrN,
  output logic            csN
);
  logic [7:0] hostData = 8'h00;
  // A released bus shows the inverse of the last value, never a held copy
  assign busToDev = busOe ? busFromDev : hostData;
  initial
  begin
    als = 1'b0;
    rdN = 1'b1;
    wrN = 1'b1;
    csN = 1'b1;
  end
  task xfer(input logic [6:0] a, input logic rd, input logic [7:0] d,
            input logic sel, output logic [7:0] q, output logic oe);
    @(posedge ref_clk);
    hostData <= {1'b0, a};
    als      <= 1'b1;
    repeat (6) @(posedge ref_clk);
    als      <= 1'b0;
    csN      <= ~sel;
    repeat (6) @(posedge ref_clk);
    hostData <= rd ? ~hostData : d;
    rdN      <= ~rd;
    wrN      <= rd;
    repeat (10) @(posedge ref_clk);
    #1;
    q  = busFromDev;
    oe = busOe;
    @(posedge ref_clk);
    rdN <= 1'b1;
    wrN <= 1'b1;
    repeat (5) @(posedge ref_clk);
    csN      <= 1'b1;
    hostData <= ~hostData;
    repeat (4) @(posedge ref_clk);
  endtask : xfer
endmodule : rtchp_host_bfm
`default_nettype wire

// file: dv/rtchp_host_port_assertions.sv
// Pin-level checks on the clock chip host port
`timescale 1ns/10ps
`default_nettype none
module rtchp_host_port_checker (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic [7:0] sharedAddrDataBusOut,
  input wire logic       sharedAddrDataBusOe,
  input wire logic       readStrobeN,
  input wire logic       chipSelectN,
  input wire logic       supplyLow,
  input wire logic       irqOut,
  input wire logic       irqOe,
  input wire logic       squareWaveOut,
  input wire logic       squareWaveOe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_irq_low_only;
    !irqOut;
  endproperty
  a_irq_low_only: assert property (p_irq_low_only)
    else $error("irq drives high");
  property p_quiet_low;
    supplyLow [*7] |-> !irqOe && !sharedAddrDataBusOe && !squareWaveOe;
  endproperty
  a_quiet_low: assert property (p_quiet_low)
    else $error("output active while supply low");
  property p_no_sqw_low;
    supplyLow [*7] |-> !squareWaveOut;
  endproperty
  a_no_sqw_low: assert property (p_no_sqw_low)
    else $error("square wave while supply low");
  property p_sqw_oe_up;
    !supplyLow [*7] |-> squareWaveOe;
  endproperty
  a_sqw_oe_up: assert property (p_sqw_oe_up)
    else $error("square wave pin not driven");
  property p_rd_release;
    readStrobeN [*7] |-> !sharedAddrDataBusOe;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("bus held after read");
  property p_cs_release;
    chipSelectN [*7] |-> !sharedAddrDataBusOe;
  endproperty
  a_cs_release: assert property (p_cs_release)
    else $error("bus driven without select");
  property p_drive_cause;
    $rose(sharedAddrDataBusOe) |->
      !$past(readStrobeN, 4) && !$past(chipSelectN, 4) && !$past(supplyLow, 4);
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("bus driven without selected read");
  property p_data_stands;
    sharedAddrDataBusOe && $past(sharedAddrDataBusOe) |-> $stable(sharedAddrDataBusOut);
  endproperty
  a_data_stands: assert property (p_data_stands)
    else $error("read data moved while driven");
endmodule : rtchp_host_port_checker
bind rtchp_host_port rtchp_host_port_checker u_rtchp_host_port_checker (
  .ref_clk, .resetn, .sharedAddrDataBusOut, .sharedAddrDataBusOe, .readStrobeN,
  .chipSelectN, .supplyLow, .irqOut, .irqOe, .squareWaveOut, .squareWaveOe);
`default_nettype wire

// file: dv/rtchp_host_port_tb_top.sv
// Self-checking bench for the clock chip host port
`timescale 1ns/10ps
`default_nettype none
module rtchp_host_port_tb_top;
  localparam int GUARD = 60;
  logic       ref_clk    = 1'b0;
  logic       resetn     = 1'b0;
  logic       supplyLow  = 1'b1;
  logic       clearN     = 1'b0;
  logic       extEn      = 1'b0;
  logic       alarmEv    = 1'b0;
  logic       updEv      = 1'b0;
  logic [7:0] q;
  logic       oe;
  int         mismatches = 0;
  int         tests_run  = 0;
  int         cycles     = 0;
  wire  [7:0] busIn;
  wire  [7:0] busOut;
  wire        busOe, als, rdN, wrN, csN, irqOut, irqOe, square_wave_out, sqwOe;
  wire        irqLine    = irqOe ? irqOut : 1'b1;  // Board pull-up

  rtchp_host_port #(.POWER_UP_CYCLES(GUARD)) u_rtchp_host_port (
    .ref_clk, .resetn, .sharedAddrDataBusIn(busIn), .sharedAddrDataBusOut(busOut),
    .sharedAddrDataBusOe(busOe), .addressLatchStrobe(als), .readStrobeN(rdN),
    .writeStrobeN(wrN), .chipSelectN(csN), .supplyLow, .userStorageClearN(clearN),
    .extAreaEnable(extEn), .alarmEvent(alarmEv), .updateEndedEvent(updEv), .irqOut,
    .irqOe, .squareWaveOut(square_wave_out), .squareWaveOe(sqwOe));
  rtchp_host_bfm u_rtchp_host_bfm (.ref_clk, .busToDev(busIn), .busFromDev(busOut),
    .busOe, .als, .rdN, .wrN, .csN);

  initial forever #12.5 ref_clk = ~ref_clk;
  // Longest waits are the slow square-wave periods
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task chkr(input string n, input int lo, input int hi, input int g);
    tests_run++;
    if (g < lo || g > hi)
    begin
      mismatches++;
      $display("MISMATCH %s exp %0d..%0d got %0d", n, lo, hi, g);
    end
  endtask : chkr
  task wr(input logic [6:0] a, input logic [7:0] d);
    u_rtchp_host_bfm.xfer(a, 1'b0, d, 1'b1, q, oe);
  endtask : wr
  task rd(input logic [6:0] a);
    u_rtchp_host_bfm.xfer(a, 1'b1, 8'h00, 1'b1, q, oe);
  endtask : rd
  task rdchk(input string n, input logic [6:0] a, input logic [7:0] e);
    rd(a);
    chk(n, e, q);
  endtask : rdchk
  task pulse(input logic upd);
    @(posedge ref_clk);
    alarmEv <= ~upd;
    updEv   <= upd;
    @(posedge ref_clk);
    alarmEv <= 1'b0;
    updEv   <= 1'b0;
    @(negedge ref_clk);
  endtask : pulse
  task waitIrq(output int t);
    t = cycles;
    while (irqLine !== 1'b0 && cycles - t < 6000) @(negedge ref_clk);
    t = cycles;
  endtask : waitIrq

  task t_regs;
    logic b;
    rdchk("rateRst", 7'h0a, 8'h26);
    rdchk("modeRst", 7'h0b, 8'h00);
    wr(7'h0c, 8'hff);
    wr(7'h0d, 8'h00);
    rdchk("flagsRo", 7'h0c, 8'h00);
    rdchk("validRo", 7'h0d, 8'h80);
    wr(7'h0a, 8'ha3);
    rdchk("rateTop", 7'h0a, 8'h23);
    wr(7'h0a, 8'h26);
    wr(7'h00, 8'h95);
    rd(7'h00);
    b = q[7];
    chk("secLow", 8'h15, q & 8'h7f);
    wr(7'h00, 8'h2a);
    rdchk("secTop", 7'h00, {b, 7'h2a});
    $display("regs done");
  endtask : t_regs
  task t_storage;
    rdchk("fill0e", 7'h0e, 8'hff);
    rdchk("fill7f", 7'h7f, 8'hff);
    wr(7'h40, 8'h5a);
    rdchk("user40", 7'h40, 8'h5a);
    @(posedge ref_clk) extEn <= 1'b1;
    wr(7'h41, 8'h3c);
    @(posedge ref_clk) extEn <= 1'b0;
    rdchk("std41", 7'h41, 8'hff);
    @(posedge ref_clk) extEn <= 1'b1;
    rdchk("ext41", 7'h41, 8'h3c);
    @(posedge ref_clk) extEn <= 1'b0;
    $display("storage done");
  endtask : t_storage
  task t_refuse;
    u_rtchp_host_bfm.xfer(7'h20, 1'b0, 8'h00, 1'b0, q, oe);
    u_rtchp_host_bfm.xfer(7'h20, 1'b1, 8'h00, 1'b0, q, oe);
    chk("csOffOe", 8'h00, {7'h0, oe});
    rdchk("csOffWr", 7'h20, 8'hff);
    @(posedge ref_clk) supplyLow <= 1'b1;
    wr(7'h20, 8'h00);
    chk("lowSqwOe", 8'h00, {7'h0, sqwOe});
    @(posedge ref_clk) supplyLow <= 1'b0;
    rd(7'h20);
    chk("guardOe", 8'h00, {7'h0, oe});
    repeat (GUARD) @(posedge ref_clk);
    rdchk("lowWr", 7'h20, 8'hff);
    $display("refuse done");
  endtask : t_refuse
  task t_irq;
    wr(7'h0a, 8'h20);
    rd(7'h0c);
    pulse(1'b0);
    chk("irqMasked", 8'h01, {7'h0, irqLine});
    wr(7'h0b, 8'h20);
    @(negedge ref_clk);
    chk("irqLate", 8'h00, {7'h0, irqLine});
    rdchk("flagsA", 7'h0c, 8'ha0);
    @(negedge ref_clk);
    chk("irqFreed", 8'h01, {7'h0, irqLine});
    rdchk("flagsNone", 7'h0c, 8'h00);
    wr(7'h0b, 8'h10);
    pulse(1'b1);
    chk("irqUpd", 8'h00, {7'h0, irqLine});
    rdchk("flagsU", 7'h0c, 8'h90);
    // Update event lands while the flag read is in progress
    fork
      rd(7'h0c);
      begin
        repeat (19) @(posedge ref_clk);
        pulse(1'b1);
      end
    join
    chk("flagsHeld", 8'h00, q);
    rdchk("flagsLate", 7'h0c, 8'h90);
    $display("irq done");
  endtask : t_irq
  task t_periodic;
    int t1;
    int t2;
    wr(7'h0a, 8'h23);
    wr(7'h0b, 8'h40);
    waitIrq(t1);
    rd(7'h0c);
    waitIrq(t1);
    rdchk("flagsP", 7'h0c, 8'hc0);
    waitIrq(t2);
    chkr("irqPeriod", 4868, 4898, t2 - t1);
    wr(7'h0a, 8'h20);
    rd(7'h0c);
    waitIrq(t1);
    chk("irqNone", 8'h01, {7'h0, irqLine});
    wr(7'h0b, 8'h00);
    $display("periodic done");
  endtask : t_periodic
  task t_sqw;
    int t1;
    int e;
    for (int code = 3; code < 5; code++)
    begin
      e = 4883 << (code - 3);
      wr(7'h0a, 8'h20 | 8'(code));
      wr(7'h0b, 8'h08);
      @(posedge square_wave_out);
      t1 = cycles;
      @(posedge square_wave_out);
      chkr("sqwPeriod", e - 16, e + 16, cycles - t1);
    end
    wr(7'h0b, 8'h00);
    t1 = 0;
    repeat (6000)
    begin
      @(negedge ref_clk);
      t1 += (square_wave_out !== 1'b0);
    end
    chkr("sqwHeld", 0, 0, t1);
    $display("sqw done");
  endtask : t_sqw
  task t_osc;
    wr(7'h0a, 8'h76);
    rd(7'h0a);
    chk("chainRstOe", 8'h00, {7'h0, oe});
    @(posedge ref_clk) resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (GUARD + 20) @(posedge ref_clk);
    rdchk("rateAgain", 7'h0a, 8'h26);
    $display("osc done");
  endtask : t_osc

  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk) supplyLow <= 1'b0;
    repeat (GUARD + 20) @(posedge ref_clk);
    clearN <= 1'b1;
    t_regs();
    t_storage();
    t_refuse();
    t_irq();
    t_periodic();
    t_sqw();
    t_osc();
    give_verdict();
  end
endmodule : rtchp_host_port_tb_top
`default_nettype wire
